/* File: pkg/aac_regs.svh */
// constants for the accumulator adjust and control datapath
// assumes inclusion by the datapath module only
`ifndef AAC_REGS_SVH
`define AAC_REGS_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define AAC_OPC_IDLE 8'h00
`define AAC_OPC_DECADJ 8'h27
`define AAC_OPC_ONESC 8'h2f
`define AAC_OPC_CFORCE 8'h37
`define AAC_OPC_CTOGGLE 8'h3f
`define AAC_OPC_PREFIX 8'hed
`define AAC_OPC_NEG2 8'h44

// ----------------------------------------
// flag bit positions in the flag byte
// ----------------------------------------
`define AAC_F_CARRY 0
`define AAC_F_SUB 1
`define AAC_F_PV 2
`define AAC_F_HALF 4
`define AAC_F_ZERO 6
`define AAC_F_SIGN 7

// ----------------------------------------
// timing, reset and correction values
// ----------------------------------------
`define AAC_TSTATES_PER_M 4
`define AAC_ACC_RST 8'hff
`define AAC_FLAG_RST 6'h3f
`define AAC_COR_LO 8'h06
`define AAC_COR_HI 8'h60
`define AAC_NEG_MIN 8'h80

`endif

/* File: pkg/aac_pkg.sv */
// types for the accumulator adjust and control datapath
// assumes the constants header sits beside it
package aac_pkg;
   typedef struct packed {
      logic sign;
      logic zero;
      logic half;
      logic pv;
      logic sub;
      logic carry;
   } aac_flags_s;

   typedef enum logic [2:0] {
      AAC_ST_FETCH,
      AAC_ST_EXEC,
      AAC_ST_PREFIX
   } aac_state_e;
endpackage : aac_pkg

/* File: rtl/aac_datapath.sv */
// accumulator adjust, complement, negate and carry control datapath
// assumes opcode bytes arrive one per machine cycle when op_valid_i is high;
// accumulator and flags are held here and loaded from outside via load_i
//
// Behaviour
// - opcode 27 adjusts the accumulator to packed BCD in one four-T-state machine cycle.
// - after addition adjust adds 06 and/or 60 by digit range and half-carry, carry set with 60.
// - after subtraction adjust adds 00, FA, A0 or 9A, carry set only for A0 and 9A.
// - adjust sets sign, zero and even parity from the result and keeps subtract.
// - opcode 2F inverts the accumulator, sets half-carry and subtract, keeps the rest.
// - ED 44 replaces the accumulator with zero minus it over two four-T-state cycles.
// - negating 80 leaves 80 and parity/overflow is set exactly when the input was 80.
// - negate sets carry when the input was nonzero and clears it on 00.
// - negate sets half-carry on borrow from bit 4, sign and zero from result, subtract always.
// - opcode 3F inverts carry, keeps sign, zero and parity/overflow, clears subtract.
// - carry toggle copies the old carry into half-carry.
// - opcode 37 forces carry, clears half-carry and subtract, keeps the rest.
`include "aac_regs.svh"

module aac_datapath
   import aac_pkg::*;
#(
   parameter int TSTATES_PER_M = `AAC_TSTATES_PER_M
) (
   input wire logic clk_i, // cpu clock, one t state per cycle
   input wire logic rst_i, // async reset, active high
   input wire logic op_valid_i, // opcode byte offered
   input wire logic [7:0] op_i, // opcode byte
   input wire logic load_i, // load acc and flags from outside
   input wire logic [7:0] acc_load_i, // accumulator load value
   input wire aac_flags_s flags_load_i, // flag load value
   output logic op_ready_o, // opcode byte taken this cycle
   output logic [7:0] acc_o, // accumulator
   output aac_flags_s flags_o, // flags
   output logic done_o, // one-cycle pulse at end of instruction
   output logic unknown_o // last opcode not served by this unit
);

   // ----------------------------------------
   // elaboration check
   // ----------------------------------------
   if (TSTATES_PER_M < 2) begin : g_chk
      $error("TSTATES_PER_M must be at least 2");
   end

   localparam int TW = $clog2(TSTATES_PER_M + 1);
   localparam logic [TW-1:0] T_LAST = TW'(TSTATES_PER_M - 1);

   aac_state_e state;
   logic pfx; // the opcode in opc came after the prefix byte
   logic [TW-1:0] tcnt;
   logic [7:0] opc;
   logic m_end;

   assign m_end = (tcnt == T_LAST);

   // ----------------------------------------
   // machine cycle sequencer
   // ----------------------------------------
   // a byte is taken in the first t state; the rest of the machine cycle
   // runs regardless so every opcode byte costs exactly four t states
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= AAC_ST_FETCH;
         tcnt <= '0;
         opc <= `AAC_OPC_IDLE;
         pfx <= 1'b0;
         op_ready_o <= 1'b0;
      end else begin
         op_ready_o <= 1'b0;
         case (state)
            AAC_ST_FETCH: begin
               if (op_valid_i && !load_i) begin
                  opc <= op_i;
                  pfx <= 1'b0;
                  op_ready_o <= 1'b1;
                  tcnt <= TW'(1);
                  state <= (op_i == `AAC_OPC_PREFIX) ? AAC_ST_PREFIX : AAC_ST_EXEC;
               end
            end
            AAC_ST_PREFIX: begin
               if (m_end) begin
                  tcnt <= '0;
               end else if (tcnt != '0) begin
                  tcnt <= tcnt + TW'(1);
               end else if (op_valid_i) begin
                  opc <= op_i;
                  pfx <= 1'b1;
                  op_ready_o <= 1'b1;
                  tcnt <= TW'(1);
                  state <= AAC_ST_EXEC;
               end
            end
            AAC_ST_EXEC: begin
               if (m_end) begin
                  tcnt <= '0;
                  state <= AAC_ST_FETCH;
               end else begin
                  tcnt <= tcnt + TW'(1);
               end
            end
            default: begin
               state <= AAC_ST_FETCH;
            end
         endcase
      end
   end

   // ----------------------------------------
   // result computation
   // ----------------------------------------
   logic exec_end, is_neg;
   logic [3:0] lo, hi;
   logic [7:0] cor, daa_res, neg_res;
   logic daa_cy, lo_adj, hi_adj;
   logic [7:0] next_acc;
   aac_flags_s f, next_flags;

   assign f = flags_o;
   assign exec_end = (state == AAC_ST_EXEC) && m_end;
   // a lone 44 is some other instruction: negate only behind the prefix
   assign is_neg = pfx && (opc == `AAC_OPC_NEG2);
   assign lo = acc_o[3:0];
   assign hi = acc_o[7:4];

   // the correction byte: 06/60 added for addition, their negatives
   // (fa, a0, 9a) for subtraction, selected by the subtract flag
   always_comb begin
      lo_adj = f.half || (lo > 4'h9);
      hi_adj = f.carry || (acc_o > 8'h99);
      cor = {hi_adj ? `AAC_COR_HI : 8'h00} | {lo_adj ? `AAC_COR_LO : 8'h00};
      if (f.sub) begin
         cor = 8'h00 - cor;
      end
      daa_res = acc_o + cor;
      daa_cy = hi_adj;
   end

   assign neg_res = 8'h00 - acc_o;

   always_comb begin
      next_acc = acc_o;
      next_flags = f;
      if (is_neg) begin
         next_acc = neg_res;
         next_flags.sign = neg_res[7];
         next_flags.zero = (neg_res == 8'h00);
         next_flags.half = (lo != 4'h0);
         next_flags.pv = (acc_o == `AAC_NEG_MIN);
         next_flags.sub = 1'b1;
         next_flags.carry = (acc_o != 8'h00);
      end else if (!pfx) begin
         case (opc)
            `AAC_OPC_DECADJ: begin
               next_acc = daa_res;
               next_flags.sign = daa_res[7];
               next_flags.zero = (daa_res == 8'h00);
               next_flags.pv = ~^daa_res;
               next_flags.half = acc_o[4] ^ cor[4] ^ daa_res[4];
               next_flags.carry = daa_cy;
            end
            `AAC_OPC_ONESC: begin
               next_acc = ~acc_o;
               next_flags.half = 1'b1;
               next_flags.sub = 1'b1;
            end
            `AAC_OPC_CTOGGLE: begin
               next_flags.carry = ~f.carry;
               next_flags.half = f.carry;
               next_flags.sub = 1'b0;
            end
            `AAC_OPC_CFORCE: begin
               next_flags.carry = 1'b1;
               next_flags.half = 1'b0;
               next_flags.sub = 1'b0;
            end
            default: begin
               next_acc = acc_o;
            end
         endcase
      end
   end

   // ----------------------------------------
   // accumulator and flags
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_o <= `AAC_ACC_RST;
         flags_o <= aac_flags_s'(`AAC_FLAG_RST);
      end else if (load_i && state == AAC_ST_FETCH) begin
         acc_o <= acc_load_i;
         flags_o <= flags_load_i;
      end else if (exec_end) begin
         acc_o <= next_acc;
         flags_o <= next_flags;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         done_o <= 1'b0;
         unknown_o <= 1'b0;
      end else begin
         done_o <= exec_end;
         if (exec_end) begin
            unknown_o <= pfx ? !is_neg : !(opc == `AAC_OPC_IDLE || opc == `AAC_OPC_DECADJ
               || opc == `AAC_OPC_ONESC || opc == `AAC_OPC_CTOGGLE
               || opc == `AAC_OPC_CFORCE);
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_neg_carry: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_end && is_neg |=> flags_o.carry == ($past(acc_o) != 8'h00))
      else $error("negate carry wrong");
   chk_neg_value: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_end && is_neg |=> acc_o == 8'(8'h00 - $past(acc_o)))
      else $error("negate result wrong");
   chk_neg_pv: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_end && is_neg |=> flags_o.pv == ($past(acc_o) == 8'h80))
      else $error("negate overflow wrong");
   chk_neg_sub: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_end && is_neg |=> flags_o.sub && flags_o.zero == (acc_o == 8'h00))
      else $error("negate flags wrong");
   chk_cpl_inv: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_end && opc == `AAC_OPC_ONESC && !pfx |=> acc_o == ~$past(acc_o)
      && flags_o.half && flags_o.sub && flags_o.carry == $past(flags_o.carry))
      else $error("complement wrong");
   chk_ccf_swap: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_end && opc == `AAC_OPC_CTOGGLE && !pfx |=>
      flags_o.half == $past(flags_o.carry) && flags_o.carry != $past(flags_o.carry))
      else $error("carry toggle wrong");
   chk_scf_set: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_end && opc == `AAC_OPC_CFORCE && !pfx |=>
      flags_o.carry && !flags_o.half && !flags_o.sub)
      else $error("carry force wrong");
   chk_daa_flags: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_end && opc == `AAC_OPC_DECADJ && !pfx |=> flags_o.pv == ~^acc_o
      && flags_o.sign == acc_o[7] && flags_o.sub == $past(flags_o.sub))
      else $error("adjust flags wrong");
   chk_mcycle_len: assert property (@(posedge clk_i) disable iff (rst_i)
      op_ready_o && state == AAC_ST_EXEC |-> ##3 done_o)
      else $error("machine cycle length wrong");

endmodule : aac_datapath

/* File: verif/aac_datapath_tb.sv */
// self-checking bench for the accumulator adjust and control datapath
// assumes aac_pkg and aac_regs.svh are compiled ahead of this file
module aac_datapath_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import aac_pkg::*;

   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic op_valid_i = 1'b0;
   logic [7:0] op_i = 8'h00;
   logic load_i = 1'b0;
   logic [7:0] acc_load_i = 8'h00;
   aac_flags_s flags_load_i = '0;
   logic op_ready_o;
   logic [7:0] acc_o;
   aac_flags_s flags_o;
   logic done_o;
   logic unknown_o;
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;

   aac_datapath u_dut (.clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_i(op_i),
      .load_i(load_i), .acc_load_i(acc_load_i), .flags_load_i(flags_load_i),
      .op_ready_o(op_ready_o), .acc_o(acc_o), .flags_o(flags_o), .done_o(done_o),
      .unknown_o(unknown_o));

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   // --------------------------------------------
   // compare and closing tasks
   // --------------------------------------------
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk8

   task automatic chkf(input logic [5:0] exp, input aac_flags_s got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error flags expected %b seen %b", exp, got);
      end
   endtask : chkf

   task automatic chkn(input int exp, input int got);
      checks++;
      if (got != exp) begin
         num_errors++;
         $display("Error cycles expected %0d seen %0d", exp, got);
      end
   endtask : chkn

   // --------------------------------------------
   // drivers: inputs move on the falling edge only
   // --------------------------------------------
   task automatic wait_ready(output int k);
      k = 0;
      do begin
         @(negedge clk_i);
         k++;
      end while (op_ready_o !== 1'b1 && k < 20);
   endtask : wait_ready

   // load, run one instruction, then judge timing and results
   task automatic do_op(input logic [7:0] a, input logic [5:0] f, input logic [7:0] op1,
         input logic [7:0] op2, input int ncyc, input logic [7:0] ea, input logic [5:0] ef);
      int k;
      int n;
      @(negedge clk_i);
      load_i = 1'b1;
      acc_load_i = a;
      flags_load_i = f;
      @(negedge clk_i);
      load_i = 1'b0;
      op_valid_i = 1'b1;
      op_i = op1;
      wait_ready(k);
      n = 0;
      if (ncyc == 7) begin
         op_i = op2;
         wait_ready(k);
         n = k;
      end
      op_valid_i = 1'b0;
      while (done_o !== 1'b1 && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      chkn(ncyc, n);
      chk8("acc", ea, acc_o);
      chkf(ef, flags_o);
   endtask : do_op

   // independent adjust model; flags packed as sign zero half pv sub carry
   function automatic logic [13:0] daa_ref(input logic [7:0] a, input logic [5:0] f);
      logic lo;
      logic hi;
      logic [7:0] cor;
      logic [7:0] r;
      lo = f[1] ? f[3] : (f[3] || a[3:0] > 4'h9);
      hi = f[1] ? f[0] : (f[0] || a > 8'h99);
      cor = {hi ? 4'h6 : 4'h0, lo ? 4'h6 : 4'h0};
      if (f[1]) begin
         cor = 8'h00 - cor;
      end
      r = a + cor;
      return {r, r[7], r == 8'h00, a[4] ^ cor[4] ^ r[4], ~^r, f[1], hi};
   endfunction : daa_ref

   // --------------------------------------------
   // scenarios
   // --------------------------------------------
   task automatic t_daa();
      logic [13:0] v[8] = '{{8'h3c, 6'h00}, {8'h9a, 6'h00}, {8'ha0, 6'h00}, {8'h22, 6'h09},
         {8'h45, 6'h02}, {8'h0f, 6'h0a}, {8'h70, 6'h03}, {8'h66, 6'h0b}};
      logic [13:0] e;
      foreach (v[i]) begin
         e = daa_ref(v[i][13:6], v[i][5:0]);
         do_op(v[i][13:6], v[i][5:0], 8'h27, 8'h00, 3, e[13:6], e[5:0]);
      end
      $display("done adjust");
   endtask : t_daa

   task automatic t_cpl();
      do_op(8'hb4, 6'b100101, 8'h2f, 8'h00, 3, 8'h4b, 6'b101111);
      do_op(8'h00, 6'b010000, 8'h2f, 8'h00, 3, 8'hff, 6'b011010);
      $display("done complement");
   endtask : t_cpl

   task automatic t_neg();
      logic [7:0] v[5] = '{8'h00, 8'h80, 8'h98, 8'h01, 8'h10};
      logic [7:0] r;
      foreach (v[i]) begin
         r = 8'h00 - v[i];
         do_op(v[i], i[0] ? 6'h3f : 6'h00, 8'hed, 8'h44, 7, r, {r[7], r == 8'h00,
            v[i][3:0] != 4'h0, v[i] == 8'h80, 1'b1, v[i] != 8'h00});
      end
      $display("done negate");
   endtask : t_neg

   task automatic t_carry();
      for (int c = 0; c < 2; c++) begin
         do_op(8'h5a, {5'b10101, c[0]}, 8'h3f, 8'h00, 3, 8'h5a, {2'b10, c[0], 2'b00, ~c[0]});
      end
      do_op(8'h33, 6'b011110, 8'h37, 8'h00, 3, 8'h33, 6'b010101);
      $display("done carry");
   endtask : t_carry

   task automatic t_idle();
      do_op(8'hed, 6'h2a, 8'hed, 8'h45, 7, 8'hed, 6'h2a);
      chk8("unknown", 8'h01, {7'h00, unknown_o});
      do_op(8'h5a, 6'h15, 8'h00, 8'h00, 3, 8'h5a, 6'h15);
      chk8("unknown", 8'h00, {7'h00, unknown_o});
      // a lone 44 without the prefix must not negate
      do_op(8'h21, 6'h15, 8'h44, 8'h00, 3, 8'h21, 6'h15);
      chk8("unknown", 8'h01, {7'h00, unknown_o});
      $display("done idle");
   endtask : t_idle

   // reset in the middle of an instruction, then a fresh instruction
   task automatic t_reset();
      @(negedge clk_i);
      op_valid_i = 1'b1;
      op_i = 8'h2f;
      @(negedge clk_i);
      op_valid_i = 1'b0;
      rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      chk8("reset acc", 8'hff, acc_o);
      chkf(6'h3f, flags_o);
      chk8("reset pulses", 8'h00, {5'h00, op_ready_o, done_o, unknown_o});
      do_op(8'h12, 6'h00, 8'h2f, 8'h00, 3, 8'hed, 6'h0a);
      $display("done reset");
   endtask : t_reset

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         report_and_stop();
      end
   end

   initial begin
      repeat (6) @(negedge clk_i);
      rst_i = 1'b0;
      chk8("reset acc", 8'hff, acc_o);
      chkf(6'h3f, flags_o);
      t_daa();
      t_cpl();
      t_neg();
      t_carry();
      t_idle();
      t_reset();
      report_and_stop();
   end
endmodule : aac_datapath_tb
